// *** bench/lwic_core_asserts.sv ***
/*
  Port checker of the LIN, wake and interrupt control block.
  Bound into lwic_core; assumes ce stays high.
*/
`timescale 1ns/1ns
`default_nettype none
module lwic_core_chk import lwic_pkg::*; #(
  parameter int unsigned TX_TO_CYC = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire lwic_pins_t pins,
  input wire logic can_wake_evt,
  input wire logic lin_a_rx_out,
  input wire logic lin_a_tx_dom,
  input wire logic [1:0] lin_a_mode,
  input wire logic irq_out_n_oe,
  input wire logic system_reset_out_n_oe,
  input wire logic limp_home_en,
  input wire logic regulators_off,
  input wire logic can_tx_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [15:0] lo_cnt_q;
  // Low time of transmit pin a
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      lo_cnt_q <= '0;
    else if (pins.lin_a_tx_in)
      lo_cnt_q <= '0;
    else if (lo_cnt_q != 16'hFFFF)
      lo_cnt_q <= lo_cnt_q + 16'h1;
  end
  ////////////////////////////////////////////////////////////
  a_rx_idle: assert property ((lin_a_mode != LM_ACTIVE) [*2] |-> lin_a_rx_out)
    else $error("rx not high outside active");
  a_rx_follow: assert property ((lin_a_mode == LM_ACTIVE && $stable(pins.lin_a_bus)) [*5]
    |-> lin_a_rx_out == pins.lin_a_bus) else $error("rx not following bus");
  a_tx_follow: assert property ((lin_a_mode == LM_ACTIVE && !pins.lin_a_tx_in) [*4]
    ##0 (lo_cnt_q < TX_TO_CYC) |-> lin_a_tx_dom) else $error("tx not driven");
  a_tx_timeout: assert property (lo_cnt_q > TX_TO_CYC + 4 |-> !lin_a_tx_dom)
    else $error("tx still dominant after time-out");
  a_tx_release: assert property ($rose(pins.lin_a_tx_in) |-> ##3 !lin_a_tx_dom)
    else $error("tx not released");
  a_ot_outputs: assert property (system_reset_out_n_oe |-> limp_home_en && regulators_off
    && can_tx_off && !lin_a_tx_dom) else $error("overtemp outputs wrong");
  a_ot_exit: assert property (system_reset_out_n_oe && !pins.overtemp
    |-> ##[1:5] !system_reset_out_n_oe) else $error("overtemp not left");
  a_irq_can: assert property (can_wake_evt |-> ##[1:4] irq_out_n_oe)
    else $error("interrupt line not pulled");
  c_irq: cover property ($rose(irq_out_n_oe));
  c_tx_to: cover property ($fell(lin_a_tx_dom) && !pins.lin_a_tx_in);
  c_ot: cover property ($rose(system_reset_out_n_oe));
endmodule
bind lwic_core lwic_core_chk #(.TX_TO_CYC(TX_TO_CYC)) i_lwic_core_chk (.clk(clk), .reset(reset),
  .pins(pins), .can_wake_evt(can_wake_evt), .lin_a_rx_out(lin_a_rx_out), .lin_a_tx_dom(lin_a_tx_dom),
  .lin_a_mode(lin_a_mode), .irq_out_n_oe(irq_out_n_oe), .system_reset_out_n_oe(system_reset_out_n_oe),
  .limp_home_en(limp_home_en), .regulators_off(regulators_off), .can_tx_off(can_tx_off));
`default_nettype wire

// *** bench/lwic_lin_far.sv ***
/*
  Far side of the two LIN buses: pull-up, block driver and a remote node.
  Assumes remote drive comes from the testbench.
*/
`timescale 1ns/1ns
`default_nettype none
module lwic_lin_far (
  // Block drive
  input wire logic tx_dom_a,
  input wire logic tx_dom_b,
  // Remote node drive
  input wire logic rdom_a,
  input wire logic rdom_b,
  // Bus levels
  output logic bus_a,
  output logic bus_b
);
  // Pull-up unless someone drives dominant
  assign bus_a = !(tx_dom_a || rdom_a);
  assign bus_b = !(tx_dom_b || rdom_b);
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
/*
  Self-checking bench of lwic_core over AXI4-Lite and pins.
  Assumes short time-out and bias parameters.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top import lwic_pkg::*; ;
  localparam int TXC = 64;
  logic clk = 0;
  logic reset = 1;
  logic ce = 1;
  lwic_axi_req_t req = '0;
  lwic_axi_rsp_t rsp;
  lwic_pins_t pv = PINS_RST;
  lwic_pins_t pins_w;
  logic can_wake_evt = 0, wd_timeout_mode = 0, wd_overflow = 0, rdom_a = 0, rdom_b = 0;
  logic rx_a, rx_b, dom_a, dom_b, bus_a, bus_b, irq_oe, rst_oe, limp, bias;
  logic [1:0] md_a, md_b, r, c;
  logic [31:0] d;
  int n_errors = 0;
  int num_checks = 0;
  always #10 clk = ~clk;
  always_comb begin
    pins_w = pv;
    pins_w.lin_a_bus = bus_a;
    pins_w.lin_b_bus = bus_b;
  end
  lwic_core #(.TX_TO_CYC(TXC), .BIAS_SHORT_CYC(32), .BIAS_LONG_CYC(128)) i_lwic_core (.clk(clk),
    .reset(reset), .ce(ce), .axi_req(req), .axi_rsp(rsp), .pins(pins_w), .can_wake_evt(can_wake_evt),
    .wd_timeout_mode(wd_timeout_mode), .wd_overflow(wd_overflow), .lin_a_rx_out(rx_a), .lin_b_rx_out(rx_b),
    .lin_a_tx_dom(dom_a), .lin_b_tx_dom(dom_b), .lin_a_mode(md_a), .lin_b_mode(md_b), .wake_bias_out(bias),
    .irq_out_n_o(), .irq_out_n_oe(irq_oe), .system_reset_out_n_o(), .system_reset_out_n_oe(rst_oe),
    .limp_home_en(limp), .regulators_off(), .can_tx_off(), .can_standby_ctrl());
  lwic_lin_far i_lwic_lin_far (.tx_dom_a(dom_a), .tx_dom_b(dom_b), .rdom_a(rdom_a), .rdom_b(rdom_b),
    .bus_a(bus_a), .bus_b(bus_b));
  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] dt);
    logic aw, w, bv;
    bv = 0;
    @(posedge clk);
    req.awvalid <= 1;
    req.awaddr <= a;
    req.wvalid <= 1;
    req.wdata <= dt;
    req.wstrb <= 4'hF;
    req.bready <= 1;
    while (!bv) begin
      @(negedge clk);
      aw = rsp.awready;
      w = rsp.wready;
      bv = rsp.bvalid;
      @(posedge clk);
      if (aw) req.awvalid <= 0;
      if (w) req.wvalid <= 0;
    end
    req.bready <= 0;
  endtask
  task automatic rd(input logic [4:0] a);
    logic ar, rv;
    rv = 0;
    @(posedge clk);
    req.arvalid <= 1;
    req.araddr <= a;
    req.rready <= 1;
    while (!rv) begin
      @(negedge clk);
      ar = rsp.arready;
      rv = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge clk);
      if (ar) req.arvalid <= 0;
    end
    req.rready <= 0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk("register", e, d & m);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #400000;
    n_errors++;
    test_done;
  end
  initial begin
    cyc(2);
    reset <= 0;
    rdc(REG_MODE, 32'h7, 32'h0);
    rd(5'h10);
    chk("resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(REG_MODE, 32'h2);
    cyc(6);
    rdc(REG_STATUS, 32'h3C, 32'h28);
    pv.bat_above_uvr <= 0;
    cyc(6);
    rdc(REG_STATUS, 32'h8, 32'h0);
    pv.bat_above_uvr <= 1;
    wr(REG_INTCTL, 32'h1);
    rdc(REG_STATUS, 32'h3C, 32'h24);
    wr(REG_MODE, 32'h0);
    rdc(REG_STATUS, 32'h3C, 32'h04);
    wr(REG_INTCTL, 32'h0);
    wr(REG_MODE, 32'h3);
    rdom_a <= 1;
    cyc(8);
    chb("rx", 1'b0, rx_a);
    rdom_a <= 0;
    cyc(8);
    chb("rx", 1'b1, rx_a);
    pv.lin_a_tx_in <= 0;
    cyc(8);
    chb("tx", 1'b1, dom_a);
    cyc(TXC + 8);
    chb("tx", 1'b0, dom_a);
    chb("bus", 1'b1, bus_a);
    pv.lin_a_tx_in <= 1;
    cyc(4);
    pv.lin_a_tx_in <= 0;
    cyc(8);
    chb("tx", 1'b1, dom_a);
    pv.lin_a_tx_in <= 1;
    wr(REG_INTCTL, 32'h1);
    wr(REG_MODE, 32'h0);
    rdom_a <= 1;
    cyc(100);
    rdom_a <= 0;
    cyc(8);
    rdc(REG_INTSTAT, 32'h1, 32'h0);
    rdom_a <= 1;
    cyc(LIN_WAKE_CYC + 10);
    rdom_a <= 0;
    rdc(REG_INTSTAT, 32'h1, 32'h1);
    wr(REG_INTSTAT, 32'h1);
    rdc(REG_INTSTAT, 32'h1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(REG_INTCTL, {27'h0, c, 3'h0});
      wr(REG_INTSTAT, 32'h3F);
      pv.local_wake_a <= 0;
      cyc(8);
      rdc(REG_INTSTAT, 32'h8, {28'h0, c[1], 3'h0});
      wr(REG_INTSTAT, 32'h3F);
      pv.local_wake_a <= 1;
      cyc(8);
      rdc(REG_INTSTAT, 32'h8, {28'h0, c[0], 3'h0});
      chb("irq", c[0], irq_oe);
      rdc(REG_STATUS, 32'h1, {31'h0, c != WIC_OFF});
    end
    wr(REG_INTSTAT, 32'h0);
    rdc(REG_INTSTAT, 32'h8, 32'h8);
    wr(REG_INTSTAT, 32'h8);
    cyc(2);
    chb("irq", 1'b0, irq_oe);
    wr(REG_MODE, 32'h1);
    pv.local_wake_a <= 0;
    cyc(8);
    rdc(REG_MODE, 32'h3, 32'h0);
    wr(REG_INTSTAT, 32'h3F);
    can_wake_evt <= 1;
    cyc(1);
    can_wake_evt <= 0;
    pv.watchdog_disable_pin <= 0;
    cyc(4);
    wd_timeout_mode <= 1;
    cyc(4);
    rdc(REG_STATUS, 32'h40, 32'h40);
    wd_overflow <= 1;
    cyc(1);
    wd_overflow <= 0;
    cyc(2);
    rdc(REG_INTSTAT, 32'h24, 32'h24);
    pv.overtemp <= 1;
    cyc(8);
    chb("rst", 1'b1, rst_oe);
    chb("limp", 1'b1, limp);
    pv.overtemp <= 0;
    cyc(8);
    chb("rst", 1'b0, rst_oe);
    rdc(REG_MODE, 32'h3, 32'h0);
    for (int p = 32; p <= 128; p += 96) begin
      wr(REG_MODE, {29'h0, p[7], 2'h0});
      @(posedge bias);
      cyc(p - 1);
      chb("bias", 1'b0, bias);
      cyc(2);
      chb("bias", 1'b1, bias);
    end
    test_done;
  end
endmodule
`default_nettype wire

// *** rtl/lwic_core.sv ***
/*
  LIN transceiver mode control, transmit dominant time-out, local wake inputs,
  interrupt status and output, cyclic interrupt and overtemperature mode,
  with an AXI4-Lite register slave.
  Assumes one 50 MHz clock; pins arrive asynchronous, watchdog and CAN
  wake signals arrive from logic on the same clock.
*/
// Our own choices: the address map and the AXI4-Lite slave port.
// What this block does
// - LIN active only in normal mode, standby bit 0, battery above recovery.
// - Active receive output follows bus: high recessive, low dominant.
// - Standby bit 1 puts transceiver in low power with bus wake detect.
// - Standby or sleep with standby bit 0 turns transceiver off.
// - Bus wake accepted only after dominant lasts the minimum wake time.
// - Transmit falling edge starts time-out; too long low disables transmitter.
// - Transmit rising edge resets the dominant time-out timer.
// - Two-bit field per wake pin picks falling, rising, both or off.
// - Enabled wake event raises local wake interrupt in standby, normal or sleep.
// - Enabled wake event during sleep moves chip to standby.
// - Wake level bits valid only while some wake field is nonzero.
// - Bias sampling enabled: sample wake pin on bias rising edge only.
// - Bias sampling disabled: sample wake pin continuously.
// - Bias period is 16 ms or 64 ms by one select bit.
// - Open-drain interrupt pulled low while any status bit pends.
// - Status bit clears only on written one; zero leaves it.
// - Clearing bus wake status keeps the latched pending wake.
// - Pending bus wake clears on entering normal with standby bit 0.
// - Cyclic interrupt enabled when watchdog enters time-out mode in standby or normal, disable pin low.
// - Cyclic interrupt set on each watchdog overflow in time-out mode.
// - Overtemperature in normal or standby: reset low, limp home, outputs off.
// - Overtemp mode returns to standby once temperature is below threshold.
`timescale 1ns/1ns
`default_nettype none
module lwic_core import lwic_pkg::*; #(
  parameter int unsigned TX_TO_CYC = TX_DOM_TO_MS * CYC_PER_MS,
  parameter int unsigned BIAS_SHORT_CYC = BIAS_SHORT_MS * CYC_PER_MS,
  parameter int unsigned BIAS_LONG_CYC = BIAS_LONG_MS * CYC_PER_MS
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Register bus
  input wire lwic_axi_req_t axi_req,
  output var lwic_axi_rsp_t axi_rsp,
  // Asynchronous pins
  input wire lwic_pins_t pins,
  // Same-clock inputs
  input wire logic can_wake_evt,
  input wire logic wd_timeout_mode,
  input wire logic wd_overflow,
  // LIN side
  output logic lin_a_rx_out,
  output logic lin_b_rx_out,
  output logic lin_a_tx_dom,
  output logic lin_b_tx_dom,
  output logic [1:0] lin_a_mode,
  output logic [1:0] lin_b_mode,
  // Wake bias and open-drain pins
  output logic wake_bias_out,
  output logic irq_out_n_o,
  output logic irq_out_n_oe,
  output logic system_reset_out_n_o,
  output logic system_reset_out_n_oe,
  // Overtemperature actions and CAN standby control
  output logic limp_home_en,
  output logic regulators_off,
  output logic can_tx_off,
  output logic can_standby_ctrl
);

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
    return a == REG_MODE || a == REG_INTCTL || a == REG_STATUS || a == REG_INTSTAT;
  endfunction

  function automatic lwic_state_t mc_decode(input logic [1:0] code);
    if (code == MC_STANDBY) begin
      return ST_STANDBY;
    end else if (code == MC_SLEEP) begin
      return ST_SLEEP;
    end
    return ST_NORMAL;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  lwic_pins_t s1_q, s2_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q <= PINS_RST;
      s2_q <= PINS_RST;
    end else if (ce) begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  logic [1:0] tx_s, bus_s, wk_s;
  assign tx_s = {s2_q.lin_b_tx_in, s2_q.lin_a_tx_in};
  assign bus_s = {s2_q.lin_b_bus, s2_q.lin_a_bus};
  assign wk_s = {s2_q.local_wake_b, s2_q.local_wake_a};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic aw_take, w_take, do_write, ar_take;
  logic [ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  always_comb begin
    axi_rsp = '0;
    axi_rsp.awready = !aw_hold_q && !bvalid_q;
    axi_rsp.wready = !w_hold_q && !bvalid_q;
    axi_rsp.bvalid = bvalid_q;
    axi_rsp.bresp = bresp_q;
    axi_rsp.arready = !rvalid_q;
    axi_rsp.rvalid = rvalid_q;
    axi_rsp.rdata = rdata_q;
    axi_rsp.rresp = rresp_q;
  end

  assign aw_take = axi_req.awvalid && axi_rsp.awready;
  assign w_take = axi_req.wvalid && axi_rsp.wready;
  assign ar_take = axi_req.arvalid && axi_rsp.arready;
  assign do_write = ce && (aw_hold_q || aw_take) && (w_hold_q || w_take);
  assign wa = aw_hold_q ? awaddr_q : axi_req.awaddr;
  assign wd = w_hold_q ? wdata_q : axi_req.wdata;
  assign ws = w_hold_q ? wstrb_q : axi_req.wstrb;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= reg_ok(wa) ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_hold_q <= 1'b1;
          awaddr_q <= axi_req.awaddr;
        end
        if (w_take) begin
          w_hold_q <= 1'b1;
          wdata_q <= axi_req.wdata;
          wstrb_q <= axi_req.wstrb;
        end
        if (bvalid_q && axi_req.bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  lwic_state_t st_q, st_d;
  lwic_intctl_t ctl_q;
  lwic_intstat_t stat_q, set_v, clr_v;
  logic wbsel_q;
  logic mode_wr, is_norm, is_stby, is_sleep, is_hot, enter_norm, wake_any;
  logic [31:0] mode_merged, ctl_merged;
  lwic_mode_reg_t mode_new;

  assign mode_wr = do_write && wa == REG_MODE;
  assign mode_merged = wmerge({29'h0, wbsel_q, MC_STANDBY}, wd, ws);
  assign mode_new = mode_merged[$bits(lwic_mode_reg_t)-1:0];
  assign ctl_merged = wmerge({23'h0, ctl_q}, wd, ws);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_q <= INTCTL_RST;
      wbsel_q <= 1'b0;
    end else if (ce) begin
      if (do_write && wa == REG_INTCTL) begin
        ctl_q <= ctl_merged[$bits(lwic_intctl_t)-1:0];
      end
      if (mode_wr) begin
        wbsel_q <= mode_new.wake_bias_period_sel;
      end
    end
  end

  assign is_norm = st_q == ST_NORMAL;
  assign is_stby = st_q == ST_STANDBY;
  assign is_sleep = st_q == ST_SLEEP;
  assign is_hot = st_q == ST_OVERTEMP;
  assign enter_norm = st_d == ST_NORMAL && !is_norm;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_STANDBY, ST_NORMAL: begin
        if (s2_q.overtemp) begin
          st_d = ST_OVERTEMP;
        end else if (mode_wr) begin
          st_d = mc_decode(mode_new.chip_mode_code);
        end
      end
      ST_SLEEP: begin
        if (wake_any) begin
          st_d = ST_STANDBY;
        end else if (mode_wr) begin
          st_d = mc_decode(mode_new.chip_mode_code);
        end
      end
      ST_OVERTEMP: begin
        if (!s2_q.overtemp) begin
          st_d = ST_STANDBY;
        end
      end
      default: st_d = ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= ST_STANDBY;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LIN channels
  logic [1:0] stb, act, tx_prev_q, blk_q, pend_q, rx_q, txdom_q, hit;
  logic [1:0] lm [2];
  logic [CNT_W-1:0] to_cnt_q [2];
  logic [CNT_W-1:0] wk_cnt_q [2];

  assign stb = {ctl_q.lin_b_standby_ctrl, ctl_q.lin_a_standby_ctrl};

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      act[i] = is_norm && !stb[i] && s2_q.bat_above_uvr;
      if (act[i]) begin
        lm[i] = LM_ACTIVE;
      end else if (stb[i]) begin
        lm[i] = LM_LOWPWR;
      end else begin
        lm[i] = LM_OFF;
      end
      hit[i] = stb[i] && !bus_s[i] && wk_cnt_q[i] == CNT_W'(LIN_WAKE_CYC - 1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_prev_q <= 2'h3;
      blk_q <= 2'h0;
      to_cnt_q <= '{default: '0};
    end else if (ce) begin
      tx_prev_q <= tx_s;
      for (int i = 0; i < 2; i++) begin
        if (tx_s[i] && !tx_prev_q[i]) begin
          to_cnt_q[i] <= '0;
          blk_q[i] <= 1'b0;
        end else if (!tx_s[i] && tx_prev_q[i]) begin
          to_cnt_q[i] <= '0;
        end else if (!tx_s[i] && !blk_q[i]) begin
          if (to_cnt_q[i] == CNT_W'(TX_TO_CYC - 1)) begin
            blk_q[i] <= 1'b1;
          end else begin
            to_cnt_q[i] <= to_cnt_q[i] + 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wk_cnt_q <= '{default: '0};
      pend_q <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (!stb[i] || bus_s[i]) begin
          wk_cnt_q[i] <= '0;
        end else if (wk_cnt_q[i] != CNT_W'(LIN_WAKE_CYC)) begin
          wk_cnt_q[i] <= wk_cnt_q[i] + 1'b1;
        end
        // Status clear never touches the pending latch
        if (hit[i]) begin
          pend_q[i] <= 1'b1;
        end else if (enter_norm && !stb[i]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_q <= 2'h3;
      txdom_q <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        rx_q[i] <= act[i] ? bus_s[i] : 1'b1;
        txdom_q[i] <= act[i] && !tx_s[i] && !blk_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CAN pending wake
  logic can_pend_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      can_pend_q <= 1'b0;
    end else if (ce) begin
      if (can_wake_evt) begin
        can_pend_q <= 1'b1;
      end else if (enter_norm && !ctl_q.can_standby_ctrl) begin
        can_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake bias generator and local wake sampling
  logic [CNT_W-1:0] bcnt_q, bper;
  logic bias_q, brise_q;
  logic [1:0] samp_q, samp_en, wk_evt, wse;
  logic [1:0] wic [2];

  assign bper = wbsel_q ? CNT_W'(BIAS_LONG_CYC) : CNT_W'(BIAS_SHORT_CYC);
  assign wse = {ctl_q.wake_b_bias_sample_en, ctl_q.wake_a_bias_sample_en};
  assign wic[0] = ctl_q.wake_a_edge_cfg;
  assign wic[1] = ctl_q.wake_b_edge_cfg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bcnt_q <= '0;
      bias_q <= 1'b0;
      brise_q <= 1'b0;
    end else if (ce) begin
      brise_q <= 1'b0;
      if (bcnt_q >= bper - 1'b1) begin
        bcnt_q <= '0;
        bias_q <= 1'b1;
        brise_q <= 1'b1;
      end else begin
        bcnt_q <= bcnt_q + 1'b1;
        if (bcnt_q == (bper >> 1)) begin
          bias_q <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      samp_en[i] = wse[i] ? brise_q : 1'b1;
      case (wic[i])
        WIC_RISE: wk_evt[i] = samp_en[i] && wk_s[i] && !samp_q[i];
        WIC_FALL: wk_evt[i] = samp_en[i] && !wk_s[i] && samp_q[i];
        WIC_BOTH: wk_evt[i] = samp_en[i] && wk_s[i] != samp_q[i];
        default: wk_evt[i] = 1'b0;
      endcase
    end
  end

  assign wake_any = |wk_evt;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      samp_q <= 2'h3;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (samp_en[i]) begin
          samp_q[i] <= wk_s[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cyclic interrupt enable
  logic ci_en_q, wdto_prev_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ci_en_q <= 1'b0;
      wdto_prev_q <= 1'b0;
    end else if (ce) begin
      wdto_prev_q <= wd_timeout_mode;
      if (!wd_timeout_mode) begin
        ci_en_q <= 1'b0;
      end else if (!wdto_prev_q && (is_stby || is_norm) && !s2_q.watchdog_disable_pin) begin
        ci_en_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear
  always_comb begin
    set_v.lin_a_wake_irq = hit[0];
    set_v.lin_b_wake_irq = hit[1];
    set_v.can_wake_irq = can_wake_evt;
    set_v.local_wake_a_irq = wk_evt[0] && (is_stby || is_norm || is_sleep);
    set_v.local_wake_b_irq = wk_evt[1] && (is_stby || is_norm || is_sleep);
    set_v.cyclic_irq = wd_overflow && wd_timeout_mode && ci_en_q;
    clr_v = (do_write && wa == REG_INTSTAT && ws[0]) ? wd[$bits(lwic_intstat_t)-1:0] : '0;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stat_q <= '0;
    end else if (ce) begin
      stat_q <= (stat_q & ~clr_v) | set_v;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  lwic_status_t sts;
  lwic_mode_reg_t mrd;

  always_comb begin
    sts.overtemp = is_hot;
    sts.cyclic_en = ci_en_q;
    sts.lin_b_mode = lm[1];
    sts.lin_a_mode = lm[0];
    sts.wake_b_level_stat = (wic[0] != WIC_OFF || wic[1] != WIC_OFF) && samp_q[1];
    sts.wake_a_level_stat = (wic[0] != WIC_OFF || wic[1] != WIC_OFF) && samp_q[0];
    mrd.wake_bias_period_sel = wbsel_q;
    mrd.chip_mode_code = is_norm ? MC_NORMAL : (is_sleep ? MC_SLEEP : MC_STANDBY);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rresp_q <= reg_ok(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= '0;
        case (axi_req.araddr)
          REG_MODE: rdata_q[$bits(lwic_mode_reg_t)-1:0] <= mrd;
          REG_INTCTL: rdata_q[$bits(lwic_intctl_t)-1:0] <= ctl_q;
          REG_STATUS: rdata_q[$bits(lwic_status_t)-1:0] <= sts;
          REG_INTSTAT: rdata_q[$bits(lwic_intstat_t)-1:0] <= stat_q;
          default: rdata_q <= '0;
        endcase
      end else if (rvalid_q && axi_req.rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic hot_q, irq_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hot_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      hot_q <= is_hot;
      irq_q <= |((stat_q & ~clr_v) | set_v);
    end
  end

  assign lin_a_rx_out = rx_q[0];
  assign lin_b_rx_out = rx_q[1];
  assign lin_a_tx_dom = txdom_q[0];
  assign lin_b_tx_dom = txdom_q[1];
  assign lin_a_mode = lm[0];
  assign lin_b_mode = lm[1];
  assign wake_bias_out = bias_q;
  assign irq_out_n_o = 1'b0;
  assign irq_out_n_oe = irq_q;
  assign system_reset_out_n_o = 1'b0;
  assign system_reset_out_n_oe = hot_q;
  assign limp_home_en = hot_q;
  assign regulators_off = hot_q;
  assign can_tx_off = hot_q;
  assign can_standby_ctrl = ctl_q.can_standby_ctrl;

endmodule
`default_nettype wire

// *** rtl/lwic_pkg.sv ***
/*
  Shared constants, register layouts and carrier types of the LIN, wake and
  interrupt control block. Assumes a 50 MHz system clock.
*/
package lwic_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1_000;
  // Times in their own units
  localparam int unsigned LIN_WAKE_DOM_US = 30;
  localparam int unsigned TX_DOM_TO_MS = 20;
  localparam int unsigned BIAS_SHORT_MS = 16;
  localparam int unsigned BIAS_LONG_MS = 64;
  localparam int unsigned LIN_WAKE_CYC = LIN_WAKE_DOM_US * CYC_PER_US;
  localparam int CNT_W = 22;

  // Register bus
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] REG_MODE = 5'h00;
  localparam logic [ADDR_W-1:0] REG_INTCTL = 5'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] REG_INTSTAT = 5'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Chip mode codes
  localparam logic [1:0] MC_STANDBY = 2'h0;
  localparam logic [1:0] MC_SLEEP = 2'h1;
  localparam logic [1:0] MC_NORMAL = 2'h2;
  // Wake edge configuration codes
  localparam logic [1:0] WIC_OFF = 2'h0;
  localparam logic [1:0] WIC_RISE = 2'h1;
  localparam logic [1:0] WIC_FALL = 2'h2;
  localparam logic [1:0] WIC_BOTH = 2'h3;
  // LIN transceiver mode codes
  localparam logic [1:0] LM_OFF = 2'h0;
  localparam logic [1:0] LM_LOWPWR = 2'h1;
  localparam logic [1:0] LM_ACTIVE = 2'h2;

  typedef enum {ST_STANDBY, ST_SLEEP, ST_NORMAL, ST_OVERTEMP} lwic_state_t;

  typedef struct packed {
    logic wake_bias_period_sel;
    logic [1:0] chip_mode_code;
  } lwic_mode_reg_t;

  typedef struct packed {
    logic wake_b_bias_sample_en;
    logic wake_a_bias_sample_en;
    logic [1:0] wake_b_edge_cfg;
    logic [1:0] wake_a_edge_cfg;
    logic can_standby_ctrl;
    logic lin_b_standby_ctrl;
    logic lin_a_standby_ctrl;
  } lwic_intctl_t;

  typedef struct packed {
    logic overtemp;
    logic cyclic_en;
    logic [1:0] lin_b_mode;
    logic [1:0] lin_a_mode;
    logic wake_b_level_stat;
    logic wake_a_level_stat;
  } lwic_status_t;

  typedef struct packed {
    logic cyclic_irq;
    logic local_wake_b_irq;
    logic local_wake_a_irq;
    logic can_wake_irq;
    logic lin_b_wake_irq;
    logic lin_a_wake_irq;
  } lwic_intstat_t;

  localparam lwic_intctl_t INTCTL_RST = '0;

  typedef struct packed {
    logic watchdog_disable_pin;
    logic overtemp;
    logic bat_above_uvr;
    logic local_wake_b;
    logic local_wake_a;
    logic lin_b_bus;
    logic lin_a_bus;
    logic lin_b_tx_in;
    logic lin_a_tx_in;
  } lwic_pins_t;

  localparam lwic_pins_t PINS_RST = 9'h17F;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } lwic_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lwic_axi_rsp_t;
endpackage
